//--- core/sdd_pkg.sv
package sdd_pkg;

  // ****************************************************************
  // Register map (APB byte addresses)
  // ****************************************************************
  localparam logic [7:0] SDD_MODE_OFS   = 8'h00;
  localparam logic [7:0] SDD_DECIM_OFS  = 8'h04;
  localparam logic [7:0] SDD_CTRL_OFS   = 8'h08;
  localparam logic [7:0] SDD_STATUS_OFS = 8'h0c;
  localparam logic [7:0] SDD_RESULT_OFS = 8'h10;
  localparam logic [7:0] SDD_OFFCO_OFS  = 8'h14;
  localparam logic [7:0] SDD_GAINCO_OFS = 8'h18;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SDD_MODE_CHOPN_BIT  = 4;
  localparam int SDD_MODE_NOTCH_BIT  = 6;
  localparam int SDD_CTRL_XREF_BIT   = 0;
  localparam int SDD_CTRL_BUF_LSB    = 1;
  localparam int SDD_CTRL_BURN_BIT   = 3;
  localparam int SDD_ST_RDY_BIT      = 7;
  localparam int SDD_ST_CAL_BIT      = 5;
  localparam int SDD_ST_NOREF_BIT    = 4;
  localparam int SDD_ST_ERR_BIT      = 3;

  // ****************************************************************
  // Reset values and limits
  // ****************************************************************
  localparam logic [7:0] SDD_MODE_RST   = 8'h00;
  localparam logic [7:0] SDD_DECIM_RST  = 8'h45;
  localparam logic [7:0] SDD_CTRL_RST   = 8'h00;
  localparam logic [7:0] SDD_DECIM_MIN_NOCHOP = 8'h03;
  localparam logic [7:0] SDD_DECIM_MIN_CHOP   = 8'h0d;
  localparam logic [7:0] SDD_NOTCH_MIN        = 8'h44;
  localparam int         SDD_DECIM_MULT       = 8;
  localparam int         SDD_RES_W            = 24;

  // ****************************************************************
  // Modes and rates
  // ****************************************************************
  typedef enum logic [2:0] {
    SDD_M_IDLE   = 3'h0,
    SDD_M_SINGLE = 3'h2,
    SDD_M_CONT   = 3'h3,
    SDD_M_OFFCAL = 3'h4,
    SDD_M_GAINCAL= 3'h5
  } sdd_mode_t;

  localparam real SDD_CLK_HZ  = 100.0e6;
  localparam real SDD_MOD_HZ  = 32.768e3;
  localparam int  SDD_MOD_DIV = int'(SDD_CLK_HZ / SDD_MOD_HZ);

  typedef struct packed {
    logic                 valid;
    logic [SDD_RES_W-1:0] data;
  } sdd_word_t;

endpackage : sdd_pkg

//--- core/sdd_rate_div.sv
`timescale 1ns/1ps
`default_nettype none
module sdd_rate_div
  import sdd_pkg::*;
#(
  parameter int DIV = SDD_MOD_DIV
)(
  input  wire logic clk_sys,
  input  wire logic reset_n,
  output var  logic tick
);
  logic [15:0] cnt_q;

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || cnt_q == 16'(DIV - 1))
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_q + 16'h0001;
  end

  assign tick = reset_n && (cnt_q == 16'(DIV - 1));
endmodule : sdd_rate_div
`default_nettype wire

//--- core/sdd_sinc3.sv
`timescale 1ns/1ps
`default_nettype none
module sdd_sinc3
  import sdd_pkg::*;
#(
  parameter int AW = 32
)(
  input  wire logic            clk_sys,
  input  wire logic            reset_n,
  input  wire logic            clear,
  input  wire logic            tick,
  input  wire logic            bitIn,
  input  wire logic [10:0]     ratio,
  output var  sdd_word_t       wordOut
);
  // ****************************************************************
  // Three integrators at modulator rate, three combs at output rate
  // ****************************************************************
  logic [AW-1:0] i1_q, i2_q, i3_q, c1_q, c2_q, c3_q;
  logic [10:0]   phase_q;
  logic [AW-1:0] d1, d2, d3;
  wire  [AW-1:0] sample = bitIn ? AW'(1) : AW'(0);
  wire           dump   = tick && (phase_q >= ratio - 11'd1);

  assign d1 = i3_q - c1_q;
  assign d2 = d1 - c2_q;
  assign d3 = d2 - c3_q;

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || clear)
    begin
      {i1_q, i2_q, i3_q, c1_q, c2_q, c3_q} <= '0;
      phase_q <= 11'h000;
      wordOut <= '0;
    end
    else
    begin
      wordOut.valid <= 1'b0;
      if (tick)
      begin
        i1_q    <= i1_q + sample;
        i2_q    <= i2_q + i1_q;
        i3_q    <= i3_q + i2_q;
        phase_q <= dump ? 11'h000 : phase_q + 11'h001;
      end
      if (dump)
      begin
        c1_q    <= i3_q;
        c2_q    <= d1;
        c3_q    <= d2;
        wordOut <= '{valid: 1'b1, data: d3[SDD_RES_W-1:0]};
      end
    end
  end
endmodule : sdd_sinc3
`default_nettype wire

//--- core/sdd_decimator_top.sv
// Contract
// RULE_01: Chop on when disable bit zero, default
// RULE_02: Chop reverses inputs, averages successive outputs
// RULE_03: Decimator fed by single modulator bit
// RULE_04: Decimation ratio is word times eight
// RULE_05: Rate follows 32.768 kHz modulator clock
// RULE_06: Chop polarity toggles each output word
// RULE_07: Without chop word ranges 3 to 255
// RULE_08: With chop words below 13 become 13
// RULE_09: Missing reference flags, clamps, blocks calibration
// RULE_10: Reference loss in calibration sets error
// RULE_11: Detection uses primary reference pair only
// RULE_12: Reference select bit picks internal or external
// RULE_13: Burnout current only with buffering enabled
// RULE_14: Software checks error bits after calibration
// RULE_15: Missing reference forces result all ones
// RULE_16: Error on clamped result, cleared by mode write
// RULE_17: Line notch only for words 68 and up
// RULE_18: Mode write clears decimator and chop stage; the code clears the chop stage only when the mode written is not idle
`timescale 1ns/1ps
`default_nettype none
module sdd_decimator_top
  import sdd_pkg::*;
#(
  // Clocks per modulator sample; another system clock needs another count
  parameter int MOD_DIV = SDD_MOD_DIV
)(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        modBit,
  input  wire logic        extRefLow,
  input  wire logic        secondRefLow,
  output var  logic        chopSwap,
  output var  logic        extRefSelect,
  output var  logic [1:0]  inputBufferCtrl,
  output var  logic        burnoutEnable,
  output var  logic        lineNotchActive,
  output var  logic        modClkTick
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic modBitS1_q, modBitS2_q, refLowS1_q, refLowS2_q;

  always_ff @(posedge clk_sys)
  begin
    modBitS1_q <= modBit;
    modBitS2_q <= modBitS1_q;
    refLowS1_q <= extRefLow;
    refLowS2_q <= refLowS1_q;
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  logic [7:0]           modeReg_q, decimWord_q, ctrlReg_q;
  logic                 rdy_q, cal_q, err_q;
  logic [SDD_RES_W-1:0] result_q, offCoef_q, gainCoef_q;

  wire apbWrite  = psel && penable && pwrite;
  wire apbRead   = psel && penable && !pwrite;
  wire wrMode    = apbWrite && paddr == SDD_MODE_OFS;
  wire wrDecim   = apbWrite && paddr == SDD_DECIM_OFS;
  wire wrCtrl    = apbWrite && paddr == SDD_CTRL_OFS;
  wire wrStatus  = apbWrite && paddr == SDD_STATUS_OFS;
  wire wrOffCo   = apbWrite && paddr == SDD_OFFCO_OFS;
  wire wrGainCo  = apbWrite && paddr == SDD_GAINCO_OFS;
  wire addrKnown = paddr == SDD_MODE_OFS || paddr == SDD_DECIM_OFS ||
                   paddr == SDD_CTRL_OFS || paddr == SDD_STATUS_OFS ||
                   paddr == SDD_RESULT_OFS || paddr == SDD_OFFCO_OFS ||
                   paddr == SDD_GAINCO_OFS;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addrKnown;

  // ****************************************************************
  // Mode decode and effective decimation word
  // ****************************************************************
  wire [2:0]  modeField = modeReg_q[2:0];
  wire        chopOn    = !modeReg_q[SDD_MODE_CHOPN_BIT]; // RULE_01
  wire        running   = modeField != 3'(SDD_M_IDLE);
  wire        calMode   = modeField == 3'(SDD_M_OFFCAL) ||
                          modeField == 3'(SDD_M_GAINCAL);
  wire        startCmd  = wrMode && pwdata[2:0] != 3'(SDD_M_IDLE);
  wire [7:0]  minWord   = chopOn ? SDD_DECIM_MIN_CHOP        // RULE_08
                                 : SDD_DECIM_MIN_NOCHOP;     // RULE_07
  wire [7:0]  effWord   = decimWord_q < minWord ? minWord : decimWord_q;
  wire [10:0] ratio     = {effWord, 3'b000};                  // RULE_04
  wire        refMissing = refLowS2_q && running;             // RULE_09 RULE_11

  assign lineNotchActive = modeReg_q[SDD_MODE_NOTCH_BIT] &&
                           effWord >= SDD_NOTCH_MIN;          // RULE_17
  assign extRefSelect    = ctrlReg_q[SDD_CTRL_XREF_BIT];      // RULE_12
  assign inputBufferCtrl = ctrlReg_q[SDD_CTRL_BUF_LSB +: 2];
  assign burnoutEnable   = ctrlReg_q[SDD_CTRL_BURN_BIT] &&
                           inputBufferCtrl != 2'b00;          // RULE_13

  // ****************************************************************
  // Modulator clock and sinc filter
  // ****************************************************************
  sdd_word_t filtWord;

  sdd_rate_div #(
    .DIV (MOD_DIV)
  ) u_div (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .tick    (modClkTick)                                     // RULE_05
  );

  sdd_sinc3 #(
    .AW (36)
  ) u_sinc (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .clear   (startCmd || !running),                          // RULE_18
    .tick    (modClkTick && running),
    .bitIn   (modBitS2_q ^ (chopSwap && chopOn)),             // RULE_03 RULE_02
    .ratio   (ratio),
    .wordOut (filtWord)
  );

  // ****************************************************************
  // Chop averaging; with chop on the first word after a start has no partner, so
  // it only primes the stage and no result is produced from it
  // ****************************************************************
  logic [SDD_RES_W-1:0] prevWord_q;
  logic                 prevValid_q;
  logic                 chopSwap_q;
  logic [SDD_RES_W:0]   pairSum;
  logic [SDD_RES_W-1:0] newWord;
  logic                 newValid;

  assign chopSwap = chopSwap_q;
  assign pairSum  = {1'b0, filtWord.data} + {1'b0, prevWord_q};
  assign newWord  = chopOn ? pairSum[SDD_RES_W:1] : filtWord.data; // RULE_02
  assign newValid = filtWord.valid && (!chopOn || prevValid_q);

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || startCmd)
    begin
      prevWord_q  <= '0;                                      // RULE_18
      prevValid_q <= 1'b0;
      chopSwap_q  <= 1'b0;
    end
    else if (filtWord.valid)
    begin
      prevWord_q  <= filtWord.data;
      prevValid_q <= 1'b1;
      chopSwap_q  <= chopOn ? !chopSwap_q : 1'b0;             // RULE_06
    end
  end

  // ****************************************************************
  // Result, clamp and calibration
  // ****************************************************************
  wire [SDD_RES_W-1:0] allOnes  = '1;
  wire [SDD_RES_W-1:0] outWord  = refMissing ? allOnes : newWord; // RULE_15
  wire                 clamped  = refMissing || &newWord || ~|newWord;
  wire                 store    = newValid && !rdy_q;
  wire                 calDone  = store && calMode;
  logic                calRefBad_q;

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      modeReg_q   <= SDD_MODE_RST;
      decimWord_q <= SDD_DECIM_RST;
      ctrlReg_q   <= SDD_CTRL_RST;
      rdy_q       <= 1'b0;
      cal_q       <= 1'b0;
      err_q       <= 1'b0;
      calRefBad_q <= 1'b0;
      result_q    <= '0;
      offCoef_q   <= '0;
      gainCoef_q  <= '0;
    end
    else
    begin
      if (wrDecim)
        decimWord_q <= pwdata[7:0];
      if (wrCtrl)
        ctrlReg_q <= pwdata[7:0];
      if (wrOffCo)
        offCoef_q <= pwdata[SDD_RES_W-1:0];
      if (wrGainCo)
        gainCoef_q <= pwdata[SDD_RES_W-1:0];
      if (wrStatus && !pwdata[SDD_ST_RDY_BIT])
        rdy_q <= 1'b0;
      if (wrMode)
      begin
        modeReg_q   <= pwdata[7:0];
        rdy_q       <= 1'b0;
        cal_q       <= 1'b0;
        err_q       <= 1'b0;                                  // RULE_16
        calRefBad_q <= 1'b0;
      end
      else
      begin
        if (calMode && refMissing)
          calRefBad_q <= 1'b1;                                // RULE_10
        if (store)
        begin
          rdy_q <= 1'b1;
          if (calMode)
          begin
            cal_q <= 1'b1;
            modeReg_q[2:0] <= 3'(SDD_M_IDLE);
            if (calRefBad_q || refMissing)
              err_q <= 1'b1;                                  // RULE_10 RULE_09
            else if (modeField == 3'(SDD_M_OFFCAL))
              offCoef_q <= newWord;
            else
              gainCoef_q <= newWord;
          end
          else
          begin
            result_q <= outWord;
            if (clamped)
              err_q <= 1'b1;                                  // RULE_16
            if (modeField == 3'(SDD_M_SINGLE))
              modeReg_q[2:0] <= 3'(SDD_M_IDLE);
          end
        end
      end
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  wire [7:0] statusByte = {rdy_q, 1'b0, cal_q, refMissing, err_q, 3'b000};

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        SDD_MODE_OFS:   prdata <= {24'h000000, modeReg_q};
        SDD_DECIM_OFS:  prdata <= {24'h000000, decimWord_q};
        SDD_CTRL_OFS:   prdata <= {24'h000000, ctrlReg_q};
        SDD_STATUS_OFS: prdata <= {24'h000000, statusByte};
        SDD_RESULT_OFS: prdata <= {8'h00, result_q};
        SDD_OFFCO_OFS:  prdata <= {8'h00, offCoef_q};
        SDD_GAINCO_OFS: prdata <= {8'h00, gainCoef_q};
        default:        prdata <= 32'h00000000;
      endcase
    end
  end

  wire unusedSecondRef = secondRefLow || apbRead;
endmodule : sdd_decimator_top
`default_nettype wire

//--- testbench/sdd_decimator_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sdd_decimator_chk
  import sdd_pkg::*;
#(
  parameter int MOD_DIV = SDD_MOD_DIV
)(
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        extRefSelect,
  input wire logic [1:0]  inputBufferCtrl,
  input wire logic        burnoutEnable,
  input wire logic        lineNotchActive,
  input wire logic        modClkTick
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ****
  // Shadow of the write side
  // ****
  logic        acc;
  logic        wr;
  logic        mapped;
  logic [3:0]  ctrlQ;
  logic [7:0]  decimQ;
  logic        notchQ;
  logic [12:0] gapQ;
  logic        seenQ;
  assign acc    = psel && penable;
  assign wr     = acc && pwrite;
  assign mapped = paddr <= SDD_GAINCO_OFS && paddr[1:0] == 2'h0;
  always_ff @(posedge clk_sys)
  begin
    ctrlQ  <= !reset_n ? 4'h0 : (wr && paddr == SDD_CTRL_OFS) ? pwdata[3:0] : ctrlQ;
    decimQ <= !reset_n ? SDD_DECIM_RST : (wr && paddr == SDD_DECIM_OFS) ? pwdata[7:0] : decimQ;
    notchQ <= !reset_n ? 1'b0 : (wr && paddr == SDD_MODE_OFS) ? pwdata[6] : notchQ;
    gapQ   <= (!reset_n || modClkTick) ? 13'h0 : gapQ + 13'h1;
    seenQ  <= reset_n && (seenQ || modClkTick);
  end
  // ****
  // Properties
  // ****
  AST_PREADY: assert property (pready) else $error("pready low");
  AST_SLVERR: assert property (acc |-> pslverr == !mapped) else $error("pslverr wrong");
  AST_XREF: assert property (extRefSelect == ctrlQ[0])
    else $error("reference select wrong");
  AST_BUF: assert property (inputBufferCtrl == ctrlQ[2:1])
    else $error("buffer control wrong");
  AST_BURN: assert property (burnoutEnable == (ctrlQ[3] && ctrlQ[2:1] != 2'h0))
    else $error("burnout enable wrong");
  AST_NOTCH: assert property (lineNotchActive == (notchQ && decimQ >= SDD_NOTCH_MIN))
    else $error("notch enable wrong");
  AST_TICK_GAP: assert property (modClkTick && seenQ |-> gapQ == MOD_DIV - 1)
    else $error("tick period wrong");
  AST_TICK_LATE: assert property (seenQ |-> gapQ < MOD_DIV)
    else $error("tick missing");
  AST_TICK_PULSE: assert property (modClkTick |=> !modClkTick [*8])
    else $error("tick too wide");
  cover property (burnoutEnable);
  cover property (lineNotchActive);
  cover property (acc && !mapped);
endmodule : sdd_decimator_chk
bind sdd_decimator_top sdd_decimator_chk #(.MOD_DIV(MOD_DIV)) chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .extRefSelect(extRefSelect), .inputBufferCtrl(inputBufferCtrl),
  .burnoutEnable(burnoutEnable), .lineNotchActive(lineNotchActive),
  .modClkTick(modClkTick)
);
`default_nettype wire

//--- testbench/sdd_mod_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdd_mod_model
(
  input  wire logic clk_sys,
  input  wire logic modClkTick,
  input  wire logic primMiss,
  input  wire logic secMiss,
  output var  logic modBit,
  output var  logic extRefLow,
  output var  logic secondRefLow
);
  logic [2:0] phaseQ = 3'h0;
  always @(posedge clk_sys)
    if (modClkTick)
      phaseQ <= phaseQ + 3'h1;
  // Comparator stream changes only on modulator ticks, like the real loop
  assign modBit       = phaseQ[0] ^ phaseQ[2];
  assign extRefLow    = primMiss;
  assign secondRefLow = secMiss;
endmodule : sdd_mod_model
`default_nettype wire

//--- testbench/sdd_decimator_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module sdd_decimator_top_test
  import sdd_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready, pslverr, modBit, extRefLow, secondRefLow, chopSwap;
  logic        extRefSelect, burnoutEnable, lineNotchActive, modClkTick;
  logic [1:0]  inputBufferCtrl;
  logic        primMiss = 1'b0;
  logic        secMiss = 1'b0;
  int          nMismatch = 0;
  int          samplesChecked = 0;
  int          cycles = 0;
  int          n;
  // Short modulator period so chopped and calibration runs fit the budget
  localparam int TB_DIV = 10;
  always #5 clk_sys = ~clk_sys;
  sdd_decimator_top #(.MOD_DIV(TB_DIV)) uut (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modBit(modBit), .extRefLow(extRefLow), .secondRefLow(secondRefLow),
    .chopSwap(chopSwap), .extRefSelect(extRefSelect), .inputBufferCtrl(inputBufferCtrl),
    .burnoutEnable(burnoutEnable), .lineNotchActive(lineNotchActive),
    .modClkTick(modClkTick));
  sdd_mod_model far (
    .clk_sys(clk_sys), .modClkTick(modClkTick), .primMiss(primMiss), .secMiss(secMiss),
    .modBit(modBit), .extRefLow(extRefLow), .secondRefLow(secondRefLow));
  // ****
  // Bus and report tasks
  // ****
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(nm, rd, exp);
  endtask : rdchk
  task automatic finishTest();
    $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finishTest
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      nMismatch++;
      finishTest();
    end
  end
  // ****
  // Tests
  // ****
  initial
  begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    rdchk("mode", SDD_MODE_OFS, {24'h0, SDD_MODE_RST});
    rdchk("decim", SDD_DECIM_OFS, {24'h0, SDD_DECIM_RST});
    rdchk("ctrl", SDD_CTRL_OFS, {24'h0, SDD_CTRL_RST});
    rdchk("status", SDD_STATUS_OFS, 32'h0);
    rdchk("unmapped", 8'h1c, 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 16; i++)
    begin
      apb(SDD_CTRL_OFS, 1'b1, i);
      #1;
      chk("xref", extRefSelect, i[0]);
      chk("buf", inputBufferCtrl, i[2:1]);
      chk("burn", burnoutEnable, i[3] && i[2:1] != 0);
    end
    rdchk("ctrl rb", SDD_CTRL_OFS, 32'hf);
    $display("test control pins done");
    for (int k = 0; k < 3; k++)
    begin
      apb(SDD_MODE_OFS, 1'b1, (k < 2) ? 32'h40 : 32'h0);
      apb(SDD_DECIM_OFS, 1'b1, (k == 0) ? 32'h43 : 32'h44);
      #1;
      chk("notch", lineNotchActive, k == 1);
    end
    $display("test notch done");
    for (int p = 0; p < 2; p++)
    begin
      n = 0;
      do
      begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      while (modClkTick !== 1'b1 && n < 8000);
    end
    chk("tick gap", n, TB_DIV);
    $display("test modulator tick done");
    apb(SDD_DECIM_OFS, 1'b1, 32'h3);
    // Single, chop on: word 3 runs as 13, so a filter word takes 104 ticks
    apb(SDD_MODE_OFS, 1'b1, 32'h02);
    repeat (150 * TB_DIV) @(posedge clk_sys);
    #1;
    chk("chop swap", chopSwap, 32'h1);
    rdchk("chop prime", SDD_STATUS_OFS, 32'h0);
    repeat (70 * TB_DIV) @(posedge clk_sys);
    #1;
    chk("chop back", chopSwap, 32'h0);
    rdchk("chop ready", SDD_STATUS_OFS, 32'h80);
    $display("test chop done");
    apb(SDD_OFFCO_OFS, 1'b1, 32'h123456);
    // Offset calibration, chop off; the reference drops out for 20 cycles early in the conversion
    apb(SDD_MODE_OFS, 1'b1, 32'h14);
    repeat (50) @(posedge clk_sys);
    primMiss <= 1'b1;
    repeat (20) @(posedge clk_sys);
    primMiss <= 1'b0;
    repeat (40 * TB_DIV) @(posedge clk_sys);
    rdchk("cal error", SDD_STATUS_OFS, 32'ha8);
    rdchk("offset kept", SDD_OFFCO_OFS, 32'h123456);
    apb(SDD_MODE_OFS, 1'b1, 32'h15);
    repeat (40 * TB_DIV) @(posedge clk_sys);
    rdchk("cal clean", SDD_STATUS_OFS, 32'ha0);
    $display("test calibration done");
    // Continuous, chop off, so the word 3 is legal and one word is short
    apb(SDD_MODE_OFS, 1'b1, 32'h13);
    secMiss <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rdchk("second ref", SDD_STATUS_OFS, 32'h0);
    primMiss <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rdchk("ref flag", SDD_STATUS_OFS, 32'h10);
    n = 0;
    do
    begin
      repeat (100) @(posedge clk_sys);
      apb(SDD_STATUS_OFS, 1'b0, 32'h0);
      n++;
    end
    while (rd[SDD_ST_RDY_BIT] !== 1'b1 && n < 900);
    chk("clamp status", rd, 32'h98);
    rdchk("result", SDD_RESULT_OFS, 32'h00ffffff);
    apb(SDD_MODE_OFS, 1'b1, 32'h13);
    rdchk("restart", SDD_STATUS_OFS, 32'h10);
    apb(SDD_MODE_OFS, 1'b1, 32'h0);
    rdchk("idle", SDD_STATUS_OFS, 32'h0);
    $display("test reference loss done");
    finishTest();
  end
endmodule : sdd_decimator_top_test
`default_nettype wire
